// ==== protect_map_pkg.sv ====
// constants and types shared by the sector protection map logic
package protect_map_pkg;

	// ****************************************
	// map geometry and values
	// ****************************************
	localparam int unsigned SECTOR_COUNT = 16;
	localparam logic [7:0]  MAP_RESET    = 8'h00;
	localparam logic [7:0]  MAP_ERASED   = 8'hFF;
	localparam logic [7:0]  READ_FILL    = 8'h00;
	localparam int unsigned S0A_HI       = 7;
	localparam int unsigned S0A_LO       = 6;
	localparam int unsigned S0B_HI       = 5;
	localparam int unsigned S0B_LO       = 4;
	localparam int unsigned MARK_BIT     = 7;

	// ****************************************
	// command bytes
	// ****************************************
	localparam logic [7:0] OP_PREFIX_0 = 8'h3D;
	localparam logic [7:0] OP_PREFIX_1 = 8'h2A;
	localparam logic [7:0] OP_PREFIX_2 = 8'h7F;
	localparam logic [7:0] OP_ERASE    = 8'hCF;
	localparam logic [7:0] OP_PROGRAM  = 8'hFC;
	localparam logic [7:0] OP_READ     = 8'h32;
	localparam logic [4:0] OPCODE_LEN  = 5'h04;
	localparam logic [4:0] READ_HEAD   = 5'h03;

	// ****************************************
	// self-timed cycle lengths
	// ****************************************
	localparam int unsigned CLK_FREQ_HZ            = 10_000_000;
	localparam int unsigned MAP_ERASE_TIME_MAX_US  = 50;
	localparam int unsigned MAP_PROG_TIME_MAX_US   = 50;
	localparam int unsigned ERASE_CYCLES_I =
		(MAP_ERASE_TIME_MAX_US * (CLK_FREQ_HZ / 1_000_000) > 0) ?
		MAP_ERASE_TIME_MAX_US * (CLK_FREQ_HZ / 1_000_000) : 1;
	localparam int unsigned PROG_CYCLES_I =
		(MAP_PROG_TIME_MAX_US * (CLK_FREQ_HZ / 1_000_000) > 0) ?
		MAP_PROG_TIME_MAX_US * (CLK_FREQ_HZ / 1_000_000) : 1;
	localparam logic [11:0] ERASE_LAST = 12'(ERASE_CYCLES_I - 1);
	localparam logic [11:0] PROG_LAST  = 12'(PROG_CYCLES_I - 1);

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		cmd_none,
		cmd_prefix,
		cmd_erase,
		cmd_prog,
		cmd_read,
		cmd_bad
	} cmd_type;

	typedef enum logic [1:0] {
		op_idle,
		op_erase,
		op_prog
	} op_type;

endpackage : protect_map_pkg

// ==== sector_protect_map_access.sv ====
// serial command engine for the nonvolatile sector protection map
//
// How it works
// - sixteen map bytes, one per sector
// - map erased before program; program only clears
// - sectors 1-15 marked by FFh, clear 00h
// - byte 0 bits 7:6 and 5:4 split sector
// - map holds 00h after reset
// - 3D 2A 7F CF then release starts erase
// - erase leaves every map byte FFh
// - erase accepted whatever protection enable says
// - erased map with protection refuses every sector
// - 3D 2A 7F FC, sixteen bytes, release programs
// - busy shown during self-timed erase or program
// - seventeenth data byte wraps to location 0
// - program accepted whatever protection enable says
// - program stages bytes in buffer one
// - 32h plus three dummies reads bytes 0-15
// - reading past byte 15 gives filler data
// - release ends read, output goes undriven
// - write-protect asserted refuses map erase, program
module sector_protect_map_access (
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           rst_b,
	// serial link pins
	input  wire logic           cs_b,
	input  wire logic           sck,
	input  wire logic           si,
	output logic                so,
	output logic                so_oe,
	// protection control
	input  wire logic           wp_b,
	input  wire logic           protect_enable,
	// status and map view
	output logic                map_busy,
	output logic                buf1_clobbered,
	output logic [127:0]        protect_map,
	output logic [16:0]         sector_refused
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic                              cs_m;
		logic                              cs_s;
		logic                              cs_d;
		logic                              sck_m;
		logic                              sck_s;
		logic                              sck_d;
		logic                              si_m;
		logic                              si_s;
		logic                              wp_m;
		logic                              wp_s;
		logic [2:0]                        bit_cnt;
		logic [4:0]                        byte_cnt;
		logic [7:0]                        shreg;
		protect_map_pkg::cmd_type          cmd;
		logic [3:0]                        prog_idx;
		logic [4:0]                        rd_idx;
		logic [7:0]                        out_sh;
		logic                              so;
		logic                              so_oe;
		logic                              clobber;
		protect_map_pkg::op_type           op;
		logic [11:0]                       timer;
		logic [15:0][7:0]                  map;
		logic [15:0][7:0]                  stage;
		logic [16:0]                       guard;
	} state_type;

	state_type st;
	state_type next_st;

	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       cs_fall;
	logic       sel;
	logic [7:0] rx_byte;
	logic       byte_done;
	logic       prog_write;
	logic       read_load;
	logic [16:0] marked;

	// ****************************************
	// protection decode
	// ****************************************
	// sector 0 halves as plain assigns, like the per-sector bits below
	assign marked[0] = &st.map[0][protect_map_pkg::S0A_HI:protect_map_pkg::S0A_LO];
	assign marked[1] = &st.map[0][protect_map_pkg::S0B_HI:protect_map_pkg::S0B_LO];

	// invalid encodings are undefined; the top bit alone decides
	genvar g;
	generate
		for (g = 1; g < protect_map_pkg::SECTOR_COUNT; g++)
		begin : g_mark
			assign marked[g + 1] = st.map[g][protect_map_pkg::MARK_BIT];
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		next_st = st;
		next_st.cs_m  = cs_b;
		next_st.cs_s  = st.cs_m;
		next_st.cs_d  = st.cs_s;
		next_st.sck_m = sck;
		next_st.sck_s = st.sck_m;
		next_st.sck_d = st.sck_s;
		next_st.si_m  = si;
		next_st.si_s  = st.si_m;
		next_st.wp_m  = wp_b;
		next_st.wp_s  = st.wp_m;
		next_st.clobber = 1'b0;

		sck_rise   = st.sck_s & ~st.sck_d;
		sck_fall   = ~st.sck_s & st.sck_d;
		cs_rise    = st.cs_s & ~st.cs_d;
		cs_fall    = ~st.cs_s & st.cs_d;
		sel        = ~st.cs_s;
		rx_byte    = {st.shreg[6:0], st.si_s};
		byte_done  = sel & sck_rise & (st.bit_cnt == 3'h7);
		prog_write = byte_done & (st.cmd == protect_map_pkg::cmd_prog)
			& (st.byte_cnt >= protect_map_pkg::OPCODE_LEN);
		read_load  = byte_done & (st.cmd == protect_map_pkg::cmd_read)
			& (st.byte_cnt >= protect_map_pkg::READ_HEAD);

		if (cs_fall)
		begin
			next_st.bit_cnt  = 3'h0;
			next_st.byte_cnt = 5'h00;
			next_st.cmd      = protect_map_pkg::cmd_none;
			next_st.prog_idx = 4'h0;
			next_st.rd_idx   = 5'h00;
		end

		if (sel & sck_rise)
		begin
			next_st.shreg   = rx_byte;
			next_st.bit_cnt = st.bit_cnt + 3'h1;
		end

		if (byte_done)
		begin
			if (st.byte_cnt != 5'h1F)
				next_st.byte_cnt = st.byte_cnt + 5'h01;
			if (st.byte_cnt == 5'h00)
			begin
				if (rx_byte == protect_map_pkg::OP_PREFIX_0)
					next_st.cmd = protect_map_pkg::cmd_prefix;
				else if (rx_byte == protect_map_pkg::OP_READ)
					next_st.cmd = protect_map_pkg::cmd_read;
				else
					next_st.cmd = protect_map_pkg::cmd_bad;
			end
			else if (st.cmd == protect_map_pkg::cmd_prefix)
			begin
				if (st.byte_cnt == 5'h01 && rx_byte != protect_map_pkg::OP_PREFIX_1)
					next_st.cmd = protect_map_pkg::cmd_bad;
				else if (st.byte_cnt == 5'h02 && rx_byte != protect_map_pkg::OP_PREFIX_2)
					next_st.cmd = protect_map_pkg::cmd_bad;
				else if (st.byte_cnt == 5'h03)
				begin
					if (rx_byte == protect_map_pkg::OP_ERASE)
						next_st.cmd = protect_map_pkg::cmd_erase;
					else if (rx_byte == protect_map_pkg::OP_PROGRAM)
						next_st.cmd = protect_map_pkg::cmd_prog;
					else
						next_st.cmd = protect_map_pkg::cmd_bad;
				end
			end
		end

		// data bytes land in buffer one; the index wraps after location 15
		if (prog_write)
		begin
			next_st.stage[st.prog_idx] = rx_byte;
			next_st.prog_idx = st.prog_idx + 4'h1;
			next_st.clobber = 1'b1;
		end

		if (read_load)
		begin
			if (st.rd_idx < 5'h10)
				next_st.out_sh = st.map[st.rd_idx[3:0]];
			else
				next_st.out_sh = protect_map_pkg::READ_FILL;
			if (st.rd_idx != 5'h1F)
				next_st.rd_idx = st.rd_idx + 5'h01;
			next_st.so_oe = 1'b1;
		end

		// mode 0: change on the falling edge, host samples on the rising
		if (sel & sck_fall & st.so_oe)
		begin
			next_st.so     = st.out_sh[7];
			next_st.out_sh = {st.out_sh[6:0], 1'b0};
		end

		if (cs_rise)
		begin
			next_st.so_oe = 1'b0;
			// protection enable is not consulted for map commands
			if (st.op == protect_map_pkg::op_idle && st.wp_s && st.bit_cnt == 3'h0)
			begin
				if (st.cmd == protect_map_pkg::cmd_erase
					&& st.byte_cnt == protect_map_pkg::OPCODE_LEN)
				begin
					next_st.op    = protect_map_pkg::op_erase;
					next_st.timer = protect_map_pkg::ERASE_LAST;
				end
				else if (st.cmd == protect_map_pkg::cmd_prog
					&& st.byte_cnt >= protect_map_pkg::OPCODE_LEN)
				begin
					next_st.op    = protect_map_pkg::op_prog;
					next_st.timer = protect_map_pkg::PROG_LAST;
				end
			end
		end

		if (st.op != protect_map_pkg::op_idle)
		begin
			if (st.timer == 12'h000)
			begin
				if (st.op == protect_map_pkg::op_erase)
					next_st.map = {protect_map_pkg::SECTOR_COUNT{protect_map_pkg::MAP_ERASED}};
				else
					next_st.map = st.map & st.stage;
				next_st.op = protect_map_pkg::op_idle;
			end
			else
				next_st.timer = st.timer - 12'h001;
		end

		// a held write-protect pin protects marked sectors on its own
		next_st.guard = (protect_enable | ~st.wp_s) ? marked : 17'h0_0000;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st          <= '0;
			st.cs_m     <= 1'b1;
			st.cs_s     <= 1'b1;
			st.cs_d     <= 1'b1;
			st.wp_m     <= 1'b1;
			st.wp_s     <= 1'b1;
			st.cmd      <= protect_map_pkg::cmd_none;
			st.op       <= protect_map_pkg::op_idle;
			st.map      <= {protect_map_pkg::SECTOR_COUNT{protect_map_pkg::MAP_RESET}};
		end
		else
			st <= next_st;
	end

	assign so             = st.so;
	assign so_oe          = st.so_oe;
	assign map_busy       = (st.op != protect_map_pkg::op_idle);
	assign buf1_clobbered = st.clobber;
	assign protect_map    = st.map;
	assign sector_refused = st.guard;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	erase_fill_a: assert property (
		(st.op == protect_map_pkg::op_erase && st.timer == 12'h000) |=> (&st.map))
		else $error("map not all ones after erase");

	prog_and_a: assert property (
		(st.op == protect_map_pkg::op_prog && st.timer == 12'h000)
		|=> (st.map == ($past(st.map) & $past(st.stage))))
		else $error("program did not clear bits from staged data");

	busy_hold_a: assert property (
		(!map_busy ##1 st.op == protect_map_pkg::op_erase) |-> map_busy[*8])
		else $error("busy dropped early in erase");

	wp_block_a: assert property (
		(st.op == protect_map_pkg::op_idle && !st.wp_s) |=> !map_busy)
		else $error("map cycle started with write-protect held");

	read_float_a: assert property (
		cs_rise |=> !so_oe)
		else $error("output still driven after release");

	wrap_idx_a: assert property (
		(prog_write && st.prog_idx == 4'hF) |=> (st.prog_idx == 4'h0))
		else $error("program index did not wrap");

	short_op_a: assert property (
		(cs_rise && st.byte_cnt < protect_map_pkg::OPCODE_LEN
			&& st.op == protect_map_pkg::op_idle) |=> !map_busy)
		else $error("cycle started from partial opcode");

	erased_guard_a: assert property (
		(protect_enable && (&st.map)) |=> (&sector_refused))
		else $error("erased map left a sector open");

	read_first_a: assert property (
		(read_load && st.rd_idx == 5'h00) |=> (st.out_sh == $past(st.map[0])))
		else $error("read did not start at byte 0");

	erase_go_a: assert property (
		(cs_rise && st.cmd == protect_map_pkg::cmd_erase && st.bit_cnt == 3'h0
			&& st.byte_cnt == protect_map_pkg::OPCODE_LEN && st.wp_s
			&& st.op == protect_map_pkg::op_idle)
		|=> (st.op == protect_map_pkg::op_erase))
		else $error("valid erase not started");

	stage_write_a: assert property (
		prog_write |=> (st.stage[$past(st.prog_idx)] == $past(rx_byte) && buf1_clobbered))
		else $error("data byte not staged in buffer one");

	prog_go_a: assert property (
		(cs_rise && st.cmd == protect_map_pkg::cmd_prog && st.bit_cnt == 3'h0
			&& st.byte_cnt >= protect_map_pkg::OPCODE_LEN && st.wp_s
			&& st.op == protect_map_pkg::op_idle)
		|=> (st.op == protect_map_pkg::op_prog))
		else $error("valid program not started");

	read_fill_a: assert property (
		(read_load && st.rd_idx >= 5'h10) |=> (st.out_sh == protect_map_pkg::READ_FILL))
		else $error("read past the map gave other than filler");

	wp_guard_a: assert property (
		!st.wp_s |=> (sector_refused == $past(marked)))
		else $error("held write-protect left a marked sector open");

endmodule : sector_protect_map_access

// ==== spi_host_model.sv ====
// serial host model that drives command frames into the map block
module spi_host_model (
	// clock
	input  wire logic ref_clk,
	// link pins
	output logic      cs_b,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		cs_b = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// mode 0: sck idles low and only toggles inside a frame
	task automatic frame(input logic [7:0] q[$], output logic [7:0] r[$]);
		logic [7:0] b;
		r = {};
		cs_b = 1'b0;
		tick(4);
		foreach (q[k])
		begin
			for (int i = 7; i >= 0; i--)
			begin
				si = q[k][i];
				tick(4);
				sck = 1'b1;
				tick(4);
				// sampled late in the high phase, well after so settles
				b[i] = so;
				sck = 1'b0;
			end
			r.push_back(b);
		end
		tick(4);
		cs_b = 1'b1;
		// released line shows the inverse so no stale value passes
		si = ~si;
		tick(4);
	endtask : frame
endmodule : spi_host_model

// ==== sector_protect_map_access_tb_top.sv ====
// self-checking bench for the sector protection map block
module sector_protect_map_access_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [7:0]   op4;
		int           nb;
		logic         wp;
		logic         pen;
		int           busy;
		logic [127:0] map;
		logic [16:0]  refu;
	} row_type;

	logic         ref_clk;
	logic         rst_b;
	logic         cs_b;
	logic         sck;
	logic         si;
	logic         so;
	logic         so_oe;
	logic         wp_b;
	logic         protect_enable;
	logic         map_busy;
	logic         buf1_clobbered;
	logic [127:0] protect_map;
	logic [16:0]  sector_refused;
	int           n_fail;
	int           samples_checked;
	int           n_pulse;
	int           n_busy;
	logic [7:0]   q[$];
	logic [7:0]   rx[$];
	logic [7:0]   d;
	logic [127:0] em;
	logic [16:0]  er;
	row_type      rows [4] = '{
		'{8'hCF, 3, 1'b1, 1'b0, 0, '0, '0},
		'{8'hCF, 4, 1'b0, 1'b0, 0, '0, '0},
		'{8'hCF, 4, 1'b1, 1'b1, protect_map_pkg::ERASE_CYCLES_I, {16{8'hFF}}, 17'h1_FFFF},
		'{8'hCF, 4, 1'b1, 1'b0, protect_map_pkg::ERASE_CYCLES_I, {16{8'hFF}}, '0}
	};

	sector_protect_map_access sector_protect_map_access_inst (
		.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .si(si),
		.so(so), .so_oe(so_oe), .wp_b(wp_b), .protect_enable(protect_enable),
		.map_busy(map_busy), .buf1_clobbered(buf1_clobbered),
		.protect_map(protect_map), .sector_refused(sector_refused)
	);

	spi_host_model spi_host_model_inst (
		.ref_clk(ref_clk), .cs_b(cs_b), .sck(sck), .si(si), .so(so)
	);

	always #50 ref_clk = ~ref_clk;

	// counted on the falling edge, away from the edge that launches them
	always @(negedge ref_clk)
	begin
		if (buf1_clobbered === 1'b1)
			n_pulse++;
		if (map_busy === 1'b1)
			n_busy++;
	end

	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic end_of_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// one frame, then room for a whole self-timed cycle to finish
	task automatic run(input int settle);
		n_busy = 0;
		n_pulse = 0;
		spi_host_model_inst.frame(q, rx);
		spi_host_model_inst.tick(settle);
	endtask : run

	initial
	begin
		#5_000_000;
		n_fail++;
		end_of_test();
	end

	initial
	begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		wp_b = 1'b1;
		protect_enable = 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		rst_b = 1'b1;
		check(protect_map, '0);
		spi_host_model_inst.tick(2);
		foreach (rows[i])
		begin
			wp_b = rows[i].wp;
			protect_enable = rows[i].pen;
			q = '{8'h3D, 8'h2A, 8'h7F, rows[i].op4};
			q = q[0:rows[i].nb - 1];
			run(600);
			check(128'(n_busy), 128'(rows[i].busy));
			check(protect_map, rows[i].map);
			check(128'(sector_refused), 128'(rows[i].refu));
		end
		// program over the erased map, seventeenth byte lands in location 0
		wp_b = 1'b1;
		protect_enable = 1'b1;
		q = '{8'h3D, 8'h2A, 8'h7F, 8'hFC, 8'hC0};
		em = '0;
		er = 17'h0_0002;
		for (int k = 1; k < 16; k++)
		begin
			d = (k % 2) ? 8'hFF : 8'h00;
			q.push_back(d);
			em[8*k +: 8] = d;
			er[k+1] = d[7];
		end
		q.push_back(8'h30);
		em[7:0] = 8'h30;
		run(600);
		check(128'(n_pulse), 128'd17);
		check(128'(n_busy), 128'(protect_map_pkg::PROG_CYCLES_I));
		check(protect_map, em);
		check(128'(sector_refused), 128'(er));
		// reprogramming without erase can only clear bits
		q = '{8'h3D, 8'h2A, 8'h7F, 8'hFC};
		repeat (16) q.push_back(8'hFF);
		run(600);
		check(protect_map, em);
		q = '{8'h32, 8'h00, 8'h00, 8'h00};
		repeat (17) q.push_back(8'h00);
		run(2);
		for (int k = 0; k < 16; k++)
			check(128'(rx[4+k]), 128'(em[8*k +: 8]));
		check(128'(rx[20]), 128'(protect_map_pkg::READ_FILL));
		check(128'(so_oe), 128'd0);
		// reset in mid-run returns the map to its delivered state
		rst_b = 1'b0;
		spi_host_model_inst.tick(1);
		check(protect_map, '0);
		check(128'({map_busy, so_oe}), 128'd0);
		rst_b = 1'b1;
		spi_host_model_inst.tick(2);
		q = '{8'h32, 8'h00, 8'h00, 8'h00, 8'h00};
		run(2);
		check(128'(rx[4]), 128'(protect_map_pkg::MAP_RESET));
		end_of_test();
	end
endmodule : sector_protect_map_access_tb_top
